// file: rtl/interrupt_vector_priority.sv
// Interrupt request routing, level arbitration and vector fetch with AXI4-Lite level registers
//
// Functional notes
// - Timer 0 lower half raises request 5, vector bytes at FFF0 and FFF1.
// - Timer 0 upper half raises request 6, vector bytes at FFEE and FFEF.
// - Timer 1 upper half raises request 14, vector bytes at FFDE and FFDF.
// - Timer 1 lower half raises request 22, vector bytes at FFCE and FFCF.
// - Pulse generator 1 lower half raises request 9, vector bytes FFE8 and FFE9.
// - Pulse generator 1 upper half raises request 10, vector bytes FFE6 and FFE7.
// - Pulse generator 0 upper half raises request 12, vector bytes FFE2 and FFE3.
// - Pulse generator 0 lower half raises request 13, vector bytes FFE0 and FFE1.
// - Each line has a two-bit level; equal levels resolve lowest number first.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "ivp_params.svh"
module interrupt_vector_priority import ivp_pkg::*; #(
    parameter int NUM_LINES = 24
) (
    input  wire logic        aclk,                // System clock, 20 MHz
    input  wire logic        aresetn,             // Synchronous reset, active low
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr,        // Write address
    input  wire logic        s_axi_awvalid,       // Write address valid
    output logic             s_axi_awready,       // Write address ready
    input  wire logic [31:0] s_axi_wdata,         // Write data
    input  wire logic [3:0]  s_axi_wstrb,         // Write strobes
    input  wire logic        s_axi_wvalid,        // Write data valid
    output logic             s_axi_wready,        // Write data ready
    output logic [1:0]       s_axi_bresp,         // Write response
    output logic             s_axi_bvalid,        // Write response valid
    input  wire logic        s_axi_bready,        // Write response ready
    input  wire logic [11:0] s_axi_araddr,        // Read address
    input  wire logic        s_axi_arvalid,       // Read address valid
    output logic             s_axi_arready,       // Read address ready
    output logic [31:0]      s_axi_rdata,         // Read data
    output logic [1:0]       s_axi_rresp,         // Read response
    output logic             s_axi_rvalid,        // Read data valid
    input  wire logic        s_axi_rready,        // Read data ready
    // Peripheral requests, levels on aclk
    input  wire logic [7:0]  ext_irq,             // External channels 0-7
    input  wire logic        uart_sio_irq,        // Serial channel 0
    input  wire logic        timer0_low_irq,      // Compound timer 0 lower half
    input  wire logic        timer0_high_irq,     // Compound timer 0 upper half
    input  wire logic        lin_rx_irq,          // LIN UART reception
    input  wire logic        lin_tx_irq,          // LIN UART transmission
    input  wire logic        pulsegen1_low_irq,   // Pulse generator 1 lower half
    input  wire logic        pulsegen1_high_irq,  // Pulse generator 1 upper half
    input  wire logic        pulsegen0_high_irq,  // Pulse generator 0 upper half
    input  wire logic        pulsegen0_low_irq,   // Pulse generator 0 lower half
    input  wire logic        timer1_high_irq,     // Compound timer 1 upper half
    input  wire logic        pulse16_irq,         // 16-bit pulse generator
    input  wire logic        i2c_irq,             // Two-wire bus channel 0
    input  wire logic        adc_irq,             // A/D converter
    input  wire logic        timebase_irq,        // Time-base timer
    input  wire logic        watch_irq,           // Watch prescaler and counter
    input  wire logic        timer1_low_irq,      // Compound timer 1 lower half
    input  wire logic        flash_irq,           // Flash memory
    // CPU side
    output logic [23:0]      irq_line,            // Numbered request lines
    output logic             irq_pending,         // A request is waiting
    output irq_num_t         irq_number,          // Winning request number
    output level_t           irq_level,           // Level of the winner
    input  wire logic        fetch_req,           // Pulse: fetch winner's vector
    output logic [15:0]      vec_addr,            // Vector table byte address
    output logic             vec_rd,              // Vector byte read strobe
    input  wire logic [7:0]  vec_rdata,           // Byte, one cycle after vec_rd
    output logic [15:0]      handler_addr,        // Assembled handler address
    output logic             handler_valid        // Pulse: handler_addr ready
);
    if (NUM_LINES != 24) begin : g_bad_lines
        $error("NUM_LINES must be 24");
    end
    level_if #(.DEPTH(24), .W(2)) lv ();
    level_store #(.DEPTH(24), .W(2)) u_levels (
        .aclk    (aclk),
        .aresetn (aresetn),
        .lv      (lv)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Even location holds the upper byte; lines step down by two bytes
    function automatic logic [15:0] vec_upper(input irq_num_t n);
        vec_upper = 16'(`VEC_TOP_ADDR - {10'h000, n, 1'b0});
    endfunction : vec_upper
    // Returns {found, level, number}
    function automatic logic [7:0] pick(input logic [23:0] req, input logic [47:0] lvls);
        logic   found;
        level_t best;
        logic [4:0] num;
        found = 1'b0;
        best  = 2'h0;
        num   = 5'h00;
        for (int i = 0; i < 24; i++) begin
            // Strict compare keeps the lower number on a tie
            if (req[i] && (!found || lvls[2*i +: 2] < best)) begin
                found = 1'b1;
                best  = lvls[2*i +: 2];
                num   = 5'(i);
            end
        end
        pick = {found, best, num};
    endfunction : pick
    ////////////////////////////////////////////////////////////////////////////
    logic [23:0] nxt_irq_line;
    logic [23:0] irq_line_ff;
    // Zeros keep unused lines 21, 17 and 11 low
    assign nxt_irq_line = {flash_irq, timer1_low_irq, 1'b0, watch_irq, timebase_irq, adc_irq, 1'b0,
                           i2c_irq, pulse16_irq, timer1_high_irq, pulsegen0_low_irq,
                           pulsegen0_high_irq, 1'b0, pulsegen1_high_irq, pulsegen1_low_irq,
                           lin_tx_irq, lin_rx_irq, timer0_high_irq, timer0_low_irq, uart_sio_irq,
                           ext_irq[3:0] | ext_irq[7:4]};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_line_ff <= 24'h000000;
        end else begin
            irq_line_ff <= nxt_irq_line;
        end
    end
    assign irq_line = irq_line_ff;
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] winner;
    logic       pending_ff;
    level_t     level_ff;
    irq_num_t   number_ff;
    assign winner = pick(irq_line_ff, lv.levels);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_ff <= 1'b0;
            level_ff   <= 2'h0;
            number_ff  <= 5'h00;
        end else begin
            pending_ff <= winner[7];
            level_ff   <= winner[6:5];
            number_ff  <= winner[4:0];
        end
    end
    assign irq_pending = pending_ff;
    assign irq_level   = level_ff;
    assign irq_number  = number_ff;
    ////////////////////////////////////////////////////////////////////////////
    fetch_state_e state_ff;
    logic [15:0]  vec_addr_ff;
    logic         vec_rd_ff;
    logic [15:0]  handler_ff;
    logic         handler_valid_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff         <= FETCH_IDLE;
            vec_addr_ff      <= 16'h0000;
            vec_rd_ff        <= 1'b0;
            handler_ff       <= 16'h0000;
            handler_valid_ff <= 1'b0;
        end else begin
            vec_rd_ff        <= 1'b0;
            handler_valid_ff <= 1'b0;
            case (state_ff)
                FETCH_IDLE: begin
                    // Request ignored with nothing pending
                    if (fetch_req && pending_ff) begin
                        vec_addr_ff <= vec_upper(number_ff);
                        vec_rd_ff   <= 1'b1;
                        state_ff    <= FETCH_HI;
                    end
                end
                FETCH_HI: begin
                    state_ff <= FETCH_LO;
                end
                FETCH_LO: begin
                    handler_ff[15:8] <= vec_rdata;
                    vec_addr_ff      <= vec_addr_ff | 16'h0001;
                    vec_rd_ff        <= 1'b1;
                    state_ff         <= FETCH_DONE;
                end
                FETCH_DONE: begin
                    // Waits out the lower strobe, as FETCH_HI does for the upper
                    if (!vec_rd_ff) begin
                        handler_ff[7:0]  <= vec_rdata;
                        handler_valid_ff <= 1'b1;
                        state_ff         <= FETCH_IDLE;
                    end
                end
                default: begin
                    state_ff <= FETCH_IDLE;
                end
            endcase
        end
    end
    assign vec_addr      = vec_addr_ff;
    assign vec_rd        = vec_rd_ff;
    assign handler_addr  = handler_ff;
    assign handler_valid = handler_valid_ff;
    ////////////////////////////////////////////////////////////////////////////
    logic        aw_held_ff;
    logic        w_held_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        do_write;
    logic        wr_level;
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_level      = awaddr_ff[1:0] == 2'h0 && awaddr_ff <= `LEVEL_LAST_OFS;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 12'h000;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                // Status words are read-only but answer OKAY
                bresp_ff   <= (wr_level || awaddr_ff == `STATUS_OFS || awaddr_ff == `REQ_OFS ||
                               awaddr_ff == `HANDLER_OFS) ? `RESP_OKAY : `RESP_DECERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    assign lv.we    = do_write && wr_level && wstrb_ff[0];
    assign lv.waddr = awaddr_ff[6:2];
    assign lv.wdata = wdata_ff[1:0];
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;
    ////////////////////////////////////////////////////////////////////////////
    logic        rd_wait_ff;
    logic [11:0] araddr_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        ar_take;
    logic [31:0] nxt_rdata;
    logic [1:0]  nxt_rresp;
    // Level store read is registered, so every read answers one cycle later
    assign s_axi_arready = !rd_wait_ff && !rvalid_ff;
    assign ar_take       = s_axi_arvalid && s_axi_arready;
    assign lv.re         = ar_take;
    assign lv.raddr      = s_axi_araddr[6:2];
    always_comb begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = `RESP_OKAY;
        if (araddr_ff[1:0] == 2'h0 && araddr_ff <= `LEVEL_LAST_OFS) begin
            nxt_rdata[1:0] = lv.rdata;
        end else if (araddr_ff == `STATUS_OFS) begin
            nxt_rdata[`STAT_NUM_LSB +: 5] = number_ff;
            nxt_rdata[`STAT_LVL_LSB +: 2] = level_ff;
            nxt_rdata[`STAT_PEND_BIT]     = pending_ff;
        end else if (araddr_ff == `REQ_OFS) begin
            nxt_rdata[23:0] = irq_line_ff;
        end else if (araddr_ff == `HANDLER_OFS) begin
            nxt_rdata[15:0] = handler_ff;
        end else begin
            nxt_rresp = `RESP_DECERR;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_wait_ff <= 1'b0;
            araddr_ff  <= 12'h000;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= `RESP_OKAY;
        end else begin
            if (ar_take) begin
                rd_wait_ff <= 1'b1;
                araddr_ff  <= s_axi_araddr;
            end else if (rd_wait_ff) begin
                rd_wait_ff <= 1'b0;
                rvalid_ff  <= 1'b1;
                rdata_ff   <= nxt_rdata;
                rresp_ff   <= nxt_rresp;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;
endmodule : interrupt_vector_priority

// file: rtl/ivp_params.svh
// Register offsets, field positions, reset values and vector constants of the interrupt vector block
`ifndef IVP_PARAMS_SVH
`define IVP_PARAMS_SVH

`define LEVEL_BASE_OFS   12'h000
`define LEVEL_LAST_OFS   12'h05C
`define STATUS_OFS       12'h080
`define REQ_OFS          12'h084
`define HANDLER_OFS      12'h088

`define STAT_NUM_LSB     0
`define STAT_LVL_LSB     8
`define STAT_PEND_BIT    16

`define LEVEL_RESET      2'h3
`define VEC_TOP_ADDR     16'hFFFA
`define RESP_OKAY        2'h0
`define RESP_DECERR      2'h3

`endif

// file: rtl/ivp_pkg.sv
// Types shared by the interrupt vector block
package ivp_pkg;
    typedef logic [1:0] level_t;
    typedef logic [4:0] irq_num_t;
    typedef enum logic [3:0] {
        FETCH_IDLE = 4'h1,
        FETCH_HI   = 4'h2,
        FETCH_LO   = 4'h4,
        FETCH_DONE = 4'h8
    } fetch_state_e;
endpackage : ivp_pkg

// file: rtl/level_if.sv
// Interface between the arbiter and the level store
`timescale 1ns/100ps
interface level_if #(parameter int DEPTH = 24, parameter int W = 2);
    logic                   we;
    logic [4:0]             waddr;
    logic [W-1:0]           wdata;
    logic                   re;
    logic [4:0]             raddr;
    logic [W-1:0]           rdata;
    logic [DEPTH*W-1:0]     levels;
    modport store (input we, waddr, wdata, re, raddr, output rdata, levels);
    modport user  (output we, waddr, wdata, re, raddr, input rdata, levels);
endinterface : level_if

// file: rtl/level_store.sv
// Per-line priority level store with registered read port
`timescale 1ns/100ps
`include "ivp_params.svh"
module level_store import ivp_pkg::*; #(
    parameter int DEPTH = 24,
    parameter int W     = 2
) (
    input  wire logic aclk,      // System clock
    input  wire logic aresetn,   // Synchronous reset, active low
    level_if.store    lv         // Write, read and all-levels view
);
    logic [W-1:0] mem_ff [DEPTH];
    logic [W-1:0] rdata_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= `LEVEL_RESET;
            end
        end else if (lv.we && (int'(lv.waddr) < DEPTH)) begin
            mem_ff[lv.waddr] <= lv.wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_ff <= '0;
        end else if (lv.re) begin
            rdata_ff <= (int'(lv.raddr) < DEPTH) ? mem_ff[lv.raddr] : '0;
        end
    end

    assign lv.rdata = rdata_ff;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            lv.levels[i*W +: W] = mem_ff[i];
        end
    end
endmodule : level_store

// file: dv/ivp_properties.sv
// Port-level checks of the interrupt vector block
`timescale 1ns/100ps
module ivp_checker import ivp_pkg::*; (
    input wire logic        aclk,               // Clock
    input wire logic        aresetn,            // Reset, active low
    input wire logic [1:0]  s_axi_bresp,        // Write response
    input wire logic        s_axi_bvalid,       // Write response valid
    input wire logic        s_axi_bready,       // Write response ready
    input wire logic [31:0] s_axi_rdata,        // Read data
    input wire logic        s_axi_rvalid,       // Read valid
    input wire logic        s_axi_rready,       // Read ready
    input wire logic [7:0]  ext_irq,            // External channels
    input wire logic        timer0_low_irq,     // Timer 0 lower
    input wire logic        timer0_high_irq,    // Timer 0 upper
    input wire logic        pulsegen1_low_irq,  // Pulse gen 1 lower
    input wire logic        pulsegen1_high_irq, // Pulse gen 1 upper
    input wire logic        pulsegen0_high_irq, // Pulse gen 0 upper
    input wire logic        pulsegen0_low_irq,  // Pulse gen 0 lower
    input wire logic        timer1_high_irq,    // Timer 1 upper
    input wire logic        timer1_low_irq,     // Timer 1 lower
    input wire logic [23:0] irq_line,           // Request lines
    input wire logic        irq_pending,        // Request waiting
    input wire irq_num_t    irq_number,         // Winner
    input wire logic [15:0] vec_addr,           // Vector address
    input wire logic        vec_rd,             // Vector strobe
    input wire logic [7:0]  vec_rdata,          // Vector byte
    input wire logic [15:0] handler_addr,       // Handler address
    input wire logic        handler_valid       // Handler pulse
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_timer_lines: assert property (
        1 |=> {irq_line[22], irq_line[14], irq_line[6], irq_line[5]}
            == $past({timer1_low_irq, timer1_high_irq, timer0_high_irq, timer0_low_irq}))
        else $error("timer request lines misrouted");
    a_pulse_lines: assert property (
        1 |=> {irq_line[13], irq_line[12], irq_line[10], irq_line[9]}
            == $past({pulsegen0_low_irq, pulsegen0_high_irq, pulsegen1_high_irq, pulsegen1_low_irq}))
        else $error("pulse generator request lines misrouted");
    a_shared_ext: assert property (
        1 |=> irq_line[3:0] == $past(ext_irq[3:0] | ext_irq[7:4]))
        else $error("external lines not shared");
    a_unused_quiet: assert property (
        irq_line[11] == 1'h0 && irq_line[17] == 1'h0 && irq_line[21] == 1'h0)
        else $error("unused line raised");
    a_winner_high: assert property (
        irq_pending |-> (($past(irq_line) >> irq_number) & 24'h000001) != 24'h000000)
        else $error("winner is not a raised line");
    a_vector_upper: assert property (
        handler_valid |-> $past(vec_rd, 4)
            && $past(vec_addr, 4) == 16'hFFFA - {10'h000, $past(irq_number, 5), 1'h0})
        else $error("upper vector address wrong");
    a_lower_odd: assert property (
        handler_valid |-> $past(vec_rd, 2) && $past(vec_addr, 2) == ($past(vec_addr, 4) | 16'h0001))
        else $error("lower byte not from next odd address");
    a_handler_bytes: assert property (
        handler_valid |-> handler_addr == {$past(vec_rdata, 3), $past(vec_rdata, 1)})
        else $error("handler bytes misassembled");
    a_strobe_single: assert property (vec_rd |=> !vec_rd)
        else $error("vector strobe longer than one cycle");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule : ivp_checker

bind interrupt_vector_priority ivp_checker chk_u (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ext_irq, .timer0_low_irq, .timer0_high_irq,
    .pulsegen1_low_irq, .pulsegen1_high_irq, .pulsegen0_high_irq, .pulsegen0_low_irq, .timer1_high_irq,
    .timer1_low_irq, .irq_line, .irq_pending, .irq_number, .vec_addr, .vec_rd, .vec_rdata, .handler_addr,
    .handler_valid);

// file: dv/vector_rom.sv
// Vector table memory on the CPU side of the block
`timescale 1ns/100ps
module vector_rom (
    input  wire logic        aclk,      // System clock
    input  wire logic [15:0] vec_addr,  // Byte address
    input  wire logic        vec_rd,    // Read strobe
    output logic      [7:0]  vec_rdata  // Byte, one cycle after strobe
);
    initial vec_rdata = 8'h00;
    // Byte valid one cycle only; inverted otherwise so a late sample is caught
    always @(posedge aclk) begin
        if (vec_rd)
            vec_rdata <= vec_addr[7:0] ^ 8'hA5;
        else
            vec_rdata <= ~vec_rdata;
    end
endmodule : vector_rom

// file: dv/interrupt_vector_priority_tb.sv
// Self-checking bench for the interrupt vector block
`timescale 1ns/100ps
`include "ivp_params.svh"
module interrupt_vector_priority_tb import ivp_pkg::*;;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, fetch_req = 1'h0;
    logic [24:0] src = 25'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic irq_pending, vec_rd, handler_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [23:0] irq_line;
    irq_num_t irq_number;
    level_t irq_level;
    logic [15:0] vec_addr, handler_addr;
    logic [7:0] vec_rdata;
    int n_errors = 0;
    int n_compared = 0;
    // Request line of each source bit: ext 0-7, then the peripherals in port order
    localparam int LINE [25] = '{0, 1, 2, 3, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 12, 13, 14, 15, 16, 18, 19, 20, 22, 23};
    always #25 aclk = ~aclk;
    interrupt_vector_priority dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .ext_irq(src[7:0]), .uart_sio_irq(src[8]), .timer0_low_irq(src[9]), .timer0_high_irq(src[10]),
        .lin_rx_irq(src[11]), .lin_tx_irq(src[12]), .pulsegen1_low_irq(src[13]), .pulsegen1_high_irq(src[14]),
        .pulsegen0_high_irq(src[15]), .pulsegen0_low_irq(src[16]), .timer1_high_irq(src[17]),
        .pulse16_irq(src[18]), .i2c_irq(src[19]), .adc_irq(src[20]), .timebase_irq(src[21]),
        .watch_irq(src[22]), .timer1_low_irq(src[23]), .flash_irq(src[24]), .irq_line, .irq_pending,
        .irq_number, .irq_level, .fetch_req, .vec_addr, .vec_rd, .vec_rdata, .handler_addr, .handler_valid);
    vector_rom rom_u (.aclk, .vec_addr, .vec_rd, .vec_rdata);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    task automatic timeout();
        n_errors++;
        $display("[FAIL] handshake expected within bound seen none");
        give_verdict();
    endtask : timeout
    // One bus transfer; for reads d is the expected data, checked only on OKAY
    task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] er);
        logic ta, tw, tar, tr;
        logic [1:0] rs;
        logic [31:0] rd;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        for (int i = 0; i < 40; i++) begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tar = s_axi_arvalid & s_axi_arready;
            tr = wr ? s_axi_bvalid : s_axi_rvalid;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            @(posedge aclk);
            if (ta)
                s_axi_awvalid <= 1'h0;
            if (tw)
                s_axi_wvalid <= 1'h0;
            if (tar)
                s_axi_arvalid <= 1'h0;
            if (tr === 1'h1) begin
                s_axi_bready <= 1'h0;
                s_axi_rready <= 1'h0;
                chk("bus response", 32'(er), 32'(rs));
                if (!wr && er == `RESP_OKAY)
                    chk("read data", d, rd);
                return;
            end
        end
        timeout();
    endtask : axi
    function automatic logic [15:0] hv(input int n);
        logic [15:0] a;
        a = 16'hFFFA - 16'(2 * n);
        return {a[7:0] ^ 8'hA5, (a[7:0] | 8'h01) ^ 8'hA5};
    endfunction : hv
    task automatic fetch(input logic [15:0] exp);
        @(posedge aclk);
        fetch_req <= 1'h1;
        @(posedge aclk);
        fetch_req <= 1'h0;
        for (int i = 0; i < 10; i++) begin
            @(negedge aclk);
            if (handler_valid === 1'h1) begin
                chk("handler_addr", 32'(exp), 32'(handler_addr));
                return;
            end
        end
        timeout();
    endtask : fetch
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_bus();
        axi(1'h0, 12'h000, 32'h3, 4'h0, `RESP_OKAY);
        axi(1'h0, 12'h05C, 32'h3, 4'h0, `RESP_OKAY);
        axi(1'h1, 12'h000, 32'hFFFF_FFFE, 4'hF, `RESP_OKAY);
        axi(1'h0, 12'h000, 32'h2, 4'h0, `RESP_OKAY);
        axi(1'h1, 12'h080, 32'h0001_FFFF, 4'hF, `RESP_OKAY);
        axi(1'h0, 12'h080, 32'h0, 4'h0, `RESP_OKAY);
        axi(1'h1, 12'h0FC, 32'h1, 4'hF, `RESP_DECERR);
        axi(1'h0, 12'h0FC, 32'h0, 4'h0, `RESP_DECERR);
        axi(1'h1, 12'h000, 32'h3, 4'hF, `RESP_OKAY);
        $display("test_bus done");
    endtask : test_bus
    task automatic test_routing();
        for (int k = 0; k < 25; k++) begin
            @(posedge aclk);
            src <= 25'(1) << k;
            repeat (3) @(negedge aclk);
            chk("irq_line", 32'(24'(1) << LINE[k]), 32'(irq_line));
            chk("irq_number", LINE[k], 32'(irq_number));
            chk("irq_level", 32'h3, 32'(irq_level));
            fetch(hv(LINE[k]));
        end
        axi(1'h0, 12'h088, 32'(hv(23)), 4'h0, `RESP_OKAY);
        @(posedge aclk);
        src <= 25'h0;
        $display("test_routing done");
    endtask : test_routing
    task automatic test_priority();
        @(posedge aclk);
        src <= (25'(1) << 9) | (25'(1) << 13) | (25'(1) << 23);
        repeat (3) @(negedge aclk);
        axi(1'h0, 12'h080, 32'h0001_0305, 4'h0, `RESP_OKAY);
        axi(1'h1, 12'h058, 32'h0, 4'h0, `RESP_OKAY);
        axi(1'h0, 12'h080, 32'h0001_0305, 4'h0, `RESP_OKAY);
        axi(1'h1, 12'h058, 32'h0, 4'hF, `RESP_OKAY);
        axi(1'h0, 12'h080, 32'h0001_0016, 4'h0, `RESP_OKAY);
        axi(1'h1, 12'h024, 32'h0, 4'hF, `RESP_OKAY);
        axi(1'h1, 12'h014, 32'h1, 4'hF, `RESP_OKAY);
        axi(1'h0, 12'h080, 32'h0001_0009, 4'h0, `RESP_OKAY);
        axi(1'h0, 12'h014, 32'h1, 4'h0, `RESP_OKAY);
        fetch(hv(9));
        $display("test_priority done");
    endtask : test_priority
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        chk("irq_line after reset", 32'h0, 32'(irq_line));
        test_bus();
        test_routing();
        test_priority();
        give_verdict();
    end
endmodule : interrupt_vector_priority_tb
